// ### cpu_model.sv
// CPU side model: takes the vector on each rising irq, in multi-handler mode only.
// Assumes the controller's registered outputs.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Presentation
  input  wire logic       irq_i,
  input  wire logic [5:0] vector_i,
  input  wire logic       multi_i,
  output logic      [5:0] taken_o
);
  logic irq_q;
  always_ff @(posedge clk_i) begin
    irq_q <= rst_i ? 1'b0 : irq_i;
    if (rst_i) begin
      taken_o <= 6'h00;
    end else if (irq_i && !irq_q && multi_i) begin
      // Hardware vector is zero in single mode, so only multi mode is taken
      taken_o <= vector_i;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the interrupt controller.
// Drives the bus, sources and pins; CPU model on the far side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vic_pkg::*;
  typedef struct packed {logic [7:0] a; logic [3:0] s; word_t d; word_t e;} row_s;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        cpu_irq_o, multi_handler_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [4:0]  ext_irq_i;
  logic [5:0]  cpu_vector_o, taken;
  logic [2:0]  cpu_level_o;
  word_t       wb_dat_i, wb_dat_o, src_req_i, q;
  int          error_cnt, cmp_count, cyc_cnt, p, run;
  row_s rows [9] = '{
    '{8'h00, 4'hF, 32'hFFFF_FFFF, 32'h0000_171F}, '{8'h04, 4'hF, 32'hFFFF_FFFF, 32'h0000_073F},
    '{8'h08, 4'hF, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{8'h08, 4'h2, 32'hFFFF_FFFF, 32'hA5A5_FF5A},
    '{8'h10, 4'hF, 32'h1234_5678, 32'h1234_5678}, '{8'h20, 4'hF, 32'hFFFF_FFFF, 32'h1F1F_1F1F},
    '{8'h18, 4'hF, 32'hFFFF_FFFF, 32'h0000_0003}, '{8'h1C, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h40, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
  vectored_interrupt_controller_regs u_vectored_interrupt_controller_regs (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .src_req_i, .ext_irq_i, .cpu_irq_o, .cpu_vector_o, .cpu_level_o,
    .multi_handler_o, .irq_o);
  cpu_model u_cpu_model (.clk_i, .rst_i, .irq_i(cpu_irq_o), .vector_i(cpu_vector_o),
    .multi_i(multi_handler_o), .taken_o(taken));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string nm, input word_t e, input word_t g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until ack is sampled; a lost ack counts once
  task automatic wbx(input logic w, input logic [7:0] a, input logic [3:0] s, input word_t d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) error_cnt++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    wbx(1'b1, a, 4'hF, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input word_t e);
    wbx(1'b0, a, 4'hF, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic pulse(input word_t m);
    src_req_i <= m;
    @(posedge clk_i);
    src_req_i <= 32'h0000_0000;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    src_req_i = 32'h0000_0000;
    ext_irq_i = 5'h00;
    @(posedge clk_i);
    do_reset();
    foreach (rows[i]) begin
      wbx(1'b1, rows[i].a, rows[i].s, rows[i].d);
      rdc("readback", rows[i].a, rows[i].e);
    end
    // Second reset in mid-run
    do_reset();
    foreach (rows[i]) rdc("reset value", rows[i].a, 32'h0000_0000);
    wr(8'h00, 32'h0000_1000);
    wr(8'h10, 32'hFFFF_FFFF);
    wr(8'h20, 32'h0016_150C);
    pulse(32'h0000_000F);
    chk("cpu irq", 32'h0000_0001, {31'h0, cpu_irq_o});
    chk("vector", 32'h0000_0002, {26'h0, cpu_vector_o});
    chk("level", 32'h0000_0005, {29'h0, cpu_level_o});
    chk("taken", 32'h0000_0002, {26'h0, taken});
    rdc("flags", 8'h0C, 32'h0000_000F);
    rdc("status", 8'h04, 32'h0000_0502);
    rdc("events", 8'h14, 32'h0000_0002);
    chk("masked irq", 32'h0000_0000, {31'h0, irq_o});
    wr(8'h18, 32'h0000_0002);
    chk("irq", 32'h0000_0001, {31'h0, irq_o});
    wr(8'h10, 32'hFFFF_FFFB);
    chk("vector", 32'h0000_0001, {26'h0, cpu_vector_o});
    wr(8'h00, 32'h0000_0000);
    chk("single vector", 32'h0000_0000, {26'h0, cpu_vector_o});
    rdc("single status", 8'h04, 32'h0000_0501);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h14, 32'h0000_0003);
    chk("cleared irq", 32'h0000_0000, {31'h0, irq_o});
    wr(8'h08, 32'h0000_0014);
    for (int l = 0; l < 8; l++) begin
      for (int k = 0; k < 2; k++) begin
        p = (l == 0) ? 1 : ((k == 1 && l < 7) ? l + 1 : l);
        run = (l != 0 && p <= l);
        wr(8'h00, word_t'(l << 8));
        wr(8'h24, word_t'(p << 10));
        pulse(32'h0000_0020);
        chk("held irq", word_t'(!run), {31'h0, cpu_irq_o});
        wbx(1'b0, 8'h1C, 4'hF, 32'h0000_0000);
        chk("timer run", word_t'(run), word_t'(q != 32'h0000_0000));
        repeat (30) @(posedge clk_i);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h14, 32'h0000_0003);
      end
    end
    // Even pins rise, odd pins fall
    wr(8'h00, 32'h0000_0015);
    ext_irq_i <= 5'h1F;
    repeat (3) @(posedge clk_i);
    rdc("rise flags", 8'h0C, 32'h0000_0015);
    wr(8'h0C, 32'h0000_0000);
    ext_irq_i <= 5'h00;
    repeat (3) @(posedge clk_i);
    rdc("fall flags", 8'h0C, 32'h0000_000A);
    test_done();
  end
endmodule
`default_nettype wire

// ### vectored_interrupt_controller_regs.sv
// Interrupt controller: request flags, arbitration, proximity timer, registers.
// Assumes one clock, synchronous inputs and a classic Wishbone master.
//
// Summary of operation
// - Control bit 12 picks multi-handler mode when 1 and single-handler mode when 0.
// - Trigger level 2 to 7 lets any event of group priority 1 up to that level start the timer.
// - Trigger level 1 lets only group priority 1 events start the timer.
// - Trigger level 0 keeps the proximity timer stopped and nothing starts it.
// - Control bits 4 to 0 choose rising (1) or falling (0) edge for each external input.
// - Status bits 10 to 8 show the priority level last presented to the CPU.
// - Status bits 5 to 0 show the winning source number, also in single-handler mode where the CPU gets 0.
// - A qualifying event loads the timer from the 32-bit reload register only while the timer is at zero.
// - A source request sets its flag to 1; 0 means no request; 32 flags per register.
// - Unimplemented bits read zero and every implemented bit resets to zero.
// - Each source has an enable bit; 1 lets it be serviced, 0 blocks it.
// - Each source has a 3-bit priority (7 highest, 0 off) and a 2-bit subpriority.
`include "vic_params.svh"
`timescale 1ns/1ns
`default_nettype none

module vectored_interrupt_controller_regs
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Peripheral requests, one-cycle pulses
  input  wire logic [31:0] src_req_i,
  // External interrupt pins
  input  wire logic [4:0]  ext_irq_i,
  // CPU side
  output logic             cpu_irq_o,
  output logic      [5:0]  cpu_vector_o,
  output logic      [2:0]  cpu_level_o,
  output logic             multi_handler_o,
  // Block interrupt
  output logic             irq_o
);

  // Register state
  logic                 multi_handler_select_q, multi_handler_select_d;
  level_t               proximity_trigger_level_q, proximity_trigger_level_d;
  logic [4:0]           ext_edge_polarity_q, ext_edge_polarity_d;
  level_t               requested_priority_level_q, requested_priority_level_d;
  vector_t              presented_handler_number_q, presented_handler_number_d;
  word_t                proximity_reload_value_q, proximity_reload_value_d;
  word_t                request_flag_q, request_flag_d;
  word_t                enable_q, enable_d;
  prio_entry_t          prio_q [0:31];
  prio_entry_t          prio_d [0:31];
  logic [1:0]           evt_q, evt_d;
  logic [1:0]           evm_q, evm_d;
  word_t                timer_q, timer_d;
  logic [4:0]           ext_prev_q;
  logic                 ack_q, ack_d;
  word_t                dat_q, dat_d;
  logic                 irq_q, irq_d;
  logic                 cpu_irq_q, cpu_irq_d;
  vector_t              cpu_num_q, cpu_num_d;
  level_t               cpu_lvl_q, cpu_lvl_d;

  // Per-source events and timer qualification
  word_t                src_evt;
  word_t                src_qual;
  logic                 trig;

  // Arbitration result
  logic                 best_valid;
  level_t               best_p;
  sublevel_t            best_s;
  vector_t              best_v;

  // Bus decode
  logic                 req;
  logic                 wr;
  word_t                wmask;
  word_t                rdata;
  logic                 prio_hit;
  logic [2:0]           prio_idx;

  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_SRC; g = g + 1) begin : g_src
      if (g < `VIC_NUM_EXT) begin : g_ext
        // Edge chosen per pin; pins count as synchronous
        assign src_evt[g] = src_req_i[g] |
                            (ext_edge_polarity_q[g] ? (ext_irq_i[g] & ~ext_prev_q[g])
                                                    : (~ext_irq_i[g] & ext_prev_q[g]));
      end else begin : g_per
        assign src_evt[g] = src_req_i[g];
      end
      // Level 1 reduces to equality since priority 0 never qualifies
      assign src_qual[g] = src_evt[g] &
                           (proximity_trigger_level_q != `VIC_TRIG_OFF) &
                           (prio_q[g][4:2] != 3'h0) &
                           (prio_q[g][4:2] <= proximity_trigger_level_q);
    end
  endgenerate

  assign trig = |src_qual;

  // Arbitration over the 32 sources
  always_comb begin
    best_valid = 1'b0;
    best_p     = 3'h0;
    best_s     = 2'h0;
    best_v     = 6'h00;
    // Ascending scan with strict compare keeps the lower number on a full tie
    for (int i = 0; i < `VIC_NUM_SRC; i++) begin
      if (request_flag_q[i] && enable_q[i] && (prio_q[i][4:2] != 3'h0)) begin
        if (!best_valid || (prio_q[i][4:2] > best_p) ||
            ((prio_q[i][4:2] == best_p) && (prio_q[i][1:0] > best_s))) begin
          best_valid = 1'b1;
          best_p     = prio_q[i][4:2];
          best_s     = prio_q[i][1:0];
          best_v     = i[5:0];
        end
      end
    end
  end

  // Bus decode and read mux
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i;
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign prio_hit = (wb_adr_i >= `VIC_OFF_PRIO_BASE) && (wb_adr_i <= `VIC_OFF_PRIO_LAST);
  assign prio_idx = wb_adr_i[4:2];

  always_comb begin
    rdata = `VIC_RST_WORD;
    if (prio_hit) begin
      for (int k = 0; k < 4; k++) begin
        rdata[k*8 +: 5] = prio_q[{prio_idx, k[1:0]}];
      end
    end else begin
      unique case (wb_adr_i)
        `VIC_OFF_CONTROL: begin
          rdata[`VIC_CTL_MULTI_BIT]        = multi_handler_select_q;
          rdata[`VIC_CTL_TRIG_LSB +: 3]    = proximity_trigger_level_q;
          rdata[`VIC_CTL_POL_LSB +: 5]     = ext_edge_polarity_q;
        end
        `VIC_OFF_STATUS: begin
          rdata[`VIC_STAT_LVL_LSB +: 3]    = requested_priority_level_q;
          rdata[`VIC_STAT_NUM_LSB +: 6]    = presented_handler_number_q;
        end
        `VIC_OFF_RELOAD:   rdata = proximity_reload_value_q;
        `VIC_OFF_FLAGS:    rdata = request_flag_q;
        `VIC_OFF_ENABLE:   rdata = enable_q;
        `VIC_OFF_EVT_STAT: rdata[1:0] = evt_q;
        `VIC_OFF_EVT_MASK: rdata[1:0] = evm_q;
        `VIC_OFF_TIMER:    rdata = timer_q;
        default:           rdata = `VIC_RST_WORD;
      endcase
    end
  end

  // Next-state logic
  always_comb begin
    multi_handler_select_d     = multi_handler_select_q;
    proximity_trigger_level_d  = proximity_trigger_level_q;
    ext_edge_polarity_d        = ext_edge_polarity_q;
    requested_priority_level_d = requested_priority_level_q;
    presented_handler_number_d = presented_handler_number_q;
    proximity_reload_value_d   = proximity_reload_value_q;
    request_flag_d             = request_flag_q;
    enable_d                   = enable_q;
    for (int i = 0; i < `VIC_NUM_SRC; i++) begin
      prio_d[i] = prio_q[i];
    end
    evt_d = evt_q;
    evm_d = evm_q;

    // Single cycle answer; data and ack leave together
    ack_d = req;
    dat_d = req ? rdata : `VIC_RST_WORD;

    // Software writes, byte lanes honoured
    if (wr) begin
      if (prio_hit) begin
        for (int k = 0; k < 4; k++) begin
          if (wb_sel_i[k]) begin
            prio_d[{prio_idx, k[1:0]}] = wb_dat_i[k*8 +: 5];
          end
        end
      end else begin
        unique case (wb_adr_i)
          `VIC_OFF_CONTROL: begin
            if (wb_sel_i[1]) begin
              multi_handler_select_d    = wb_dat_i[`VIC_CTL_MULTI_BIT];
              proximity_trigger_level_d = wb_dat_i[`VIC_CTL_TRIG_LSB +: 3];
            end
            if (wb_sel_i[0]) begin
              ext_edge_polarity_d = wb_dat_i[`VIC_CTL_POL_LSB +: 5];
            end
          end
          `VIC_OFF_STATUS: begin
            if (wb_sel_i[1]) begin
              requested_priority_level_d = wb_dat_i[`VIC_STAT_LVL_LSB +: 3];
            end
            if (wb_sel_i[0]) begin
              presented_handler_number_d = wb_dat_i[`VIC_STAT_NUM_LSB +: 6];
            end
          end
          `VIC_OFF_RELOAD: begin
            proximity_reload_value_d = (proximity_reload_value_q & ~wmask) |
                                       (wb_dat_i & wmask);
          end
          `VIC_OFF_FLAGS: begin
            request_flag_d = (request_flag_q & ~wmask) | (wb_dat_i & wmask);
          end
          `VIC_OFF_ENABLE: begin
            enable_d = (enable_q & ~wmask) | (wb_dat_i & wmask);
          end
          `VIC_OFF_EVT_STAT: begin
            if (wb_sel_i[0]) begin
              evt_d = evt_q & ~wb_dat_i[1:0];
            end
          end
          `VIC_OFF_EVT_MASK: begin
            if (wb_sel_i[0]) begin
              evm_d = wb_dat_i[1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Hardware set wins over a software clear in the same cycle
    request_flag_d = request_flag_d | src_evt;

    // Proximity timer: holds presentation back while it runs
    if (proximity_trigger_level_q == `VIC_TRIG_OFF) begin
      timer_d = `VIC_RST_WORD;
    end else if (timer_q != `VIC_RST_WORD) begin
      timer_d = timer_q - 32'h0000_0001;
      if (timer_q == 32'h0000_0001) begin
        evt_d[`VIC_EVT_TIMER_BIT] = 1'b1;
      end
    end else if (trig) begin
      timer_d = proximity_reload_value_q;
    end else begin
      timer_d = timer_q;
    end

    // Presentation to the CPU
    cpu_irq_d = best_valid && (timer_q == `VIC_RST_WORD);
    cpu_num_d = multi_handler_select_q ? best_v : 6'h00;
    cpu_lvl_d = best_p;
    if (cpu_irq_d) begin
      requested_priority_level_d = best_p;
      presented_handler_number_d = best_v;
      if (!cpu_irq_q || (best_v != presented_handler_number_q)) begin
        evt_d[`VIC_EVT_PRESENT_BIT] = 1'b1;
      end
    end

    irq_d = |(evt_d & evm_d);
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      multi_handler_select_q     <= 1'b0;
      proximity_trigger_level_q  <= `VIC_RST_TRIG;
      ext_edge_polarity_q        <= `VIC_RST_POL;
      requested_priority_level_q <= 3'h0;
      presented_handler_number_q <= 6'h00;
      proximity_reload_value_q   <= `VIC_RST_WORD;
      request_flag_q             <= `VIC_RST_WORD;
      enable_q                   <= `VIC_RST_WORD;
      for (int i = 0; i < `VIC_NUM_SRC; i++) begin
        prio_q[i] <= `VIC_RST_PRIO;
      end
      evt_q      <= 2'h0;
      evm_q      <= 2'h0;
      timer_q    <= `VIC_RST_WORD;
      ext_prev_q <= 5'h00;
      ack_q      <= 1'b0;
      dat_q      <= `VIC_RST_WORD;
      irq_q      <= 1'b0;
      cpu_irq_q  <= 1'b0;
      cpu_num_q  <= 6'h00;
      cpu_lvl_q  <= 3'h0;
    end else begin
      multi_handler_select_q     <= multi_handler_select_d;
      proximity_trigger_level_q  <= proximity_trigger_level_d;
      ext_edge_polarity_q        <= ext_edge_polarity_d;
      requested_priority_level_q <= requested_priority_level_d;
      presented_handler_number_q <= presented_handler_number_d;
      proximity_reload_value_q   <= proximity_reload_value_d;
      request_flag_q             <= request_flag_d;
      enable_q                   <= enable_d;
      for (int i = 0; i < `VIC_NUM_SRC; i++) begin
        prio_q[i] <= prio_d[i];
      end
      evt_q      <= evt_d;
      evm_q      <= evm_d;
      timer_q    <= timer_d;
      ext_prev_q <= ext_irq_i;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
      irq_q      <= irq_d;
      cpu_irq_q  <= cpu_irq_d;
      cpu_num_q  <= cpu_num_d;
      cpu_lvl_q  <= cpu_lvl_d;
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign irq_o           = irq_q;
  assign cpu_irq_o       = cpu_irq_q;
  assign cpu_vector_o    = cpu_num_q;
  assign cpu_level_o     = cpu_lvl_q;
  assign multi_handler_o = multi_handler_select_q;

endmodule

`default_nettype wire

// ### vic_params.svh
// Register offsets, field positions, reset values of the interrupt controller.
// Assumes byte addresses on a 32-bit classic Wishbone slave port.
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

`define VIC_ADDR_W          8
`define VIC_OFF_CONTROL     8'h00
`define VIC_OFF_STATUS      8'h04
`define VIC_OFF_RELOAD      8'h08
`define VIC_OFF_FLAGS       8'h0C
`define VIC_OFF_ENABLE      8'h10
`define VIC_OFF_EVT_STAT    8'h14
`define VIC_OFF_EVT_MASK    8'h18
`define VIC_OFF_TIMER       8'h1C
`define VIC_OFF_PRIO_BASE   8'h20
`define VIC_OFF_PRIO_LAST   8'h3C

`define VIC_NUM_SRC         32
`define VIC_NUM_EXT         5

`define VIC_CTL_MULTI_BIT   12
`define VIC_CTL_TRIG_LSB    8
`define VIC_CTL_POL_LSB     0
`define VIC_STAT_LVL_LSB    8
`define VIC_STAT_NUM_LSB    0

`define VIC_EVT_TIMER_BIT   0
`define VIC_EVT_PRESENT_BIT 1
`define VIC_EVT_W           2

`define VIC_RST_WORD        32'h0000_0000
`define VIC_RST_PRIO        5'h00
`define VIC_RST_TRIG        3'h0
`define VIC_RST_POL         5'h00
`define VIC_TRIG_OFF        3'h0

`endif

// ### vic_pkg.sv
// Types shared by the interrupt controller.
// Assumes vic_params.svh is compiled alongside.
package vic_pkg;
  typedef logic [31:0] word_t;
  typedef logic [2:0]  level_t;
  typedef logic [1:0]  sublevel_t;
  typedef logic [5:0]  vector_t;
  typedef logic [4:0]  prio_entry_t;
endpackage

// ### vic_sva.sv
// Port checker for the interrupt controller.
// Bound to the top module; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module vic_sva (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // CPU side and block interrupt
  input wire logic        cpu_irq_o,
  input wire logic [5:0]  cpu_vector_o,
  input wire logic [2:0]  cpu_level_o,
  input wire logic        multi_handler_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_seq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ctl_wr_seq;
    req_seq ##0 (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1]);
  endsequence
  sequence stat_rd_seq;
    req_seq ##0 (!wb_we_i && wb_adr_i == 8'h04);
  endsequence
  ack_timing_a: assert property (req_seq |=> wb_ack_o)
    else $error("no ack after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  ctl_spare_a: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h00) |-> (wb_dat_o & 32'hFFFF_E8E0) == 0)
    else $error("control spare bits set");
  stat_spare_a: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h04) |-> (wb_dat_o & 32'hFFFF_F8C0) == 0)
    else $error("status spare bits set");
  mode_copy_a: assert property (
    ctl_wr_seq |-> ##2 multi_handler_o == $past(wb_dat_i[12], 2))
    else $error("mode output not written bit");
  single_vec_a: assert property (
    !multi_handler_o && $past(!multi_handler_o) |-> cpu_vector_o == 6'h00)
    else $error("vector in single mode");
  level_live_a: assert property (cpu_irq_o |-> cpu_level_o != 3'h0)
    else $error("zero priority presented");
  stat_mirror_a: assert property (
    stat_rd_seq ##0 (cpu_irq_o && $past(cpu_irq_o) && multi_handler_o && $stable(cpu_level_o)
      && $stable(cpu_vector_o)) |=> wb_dat_o[10:8] == $past(cpu_level_o)
      && wb_dat_o[5:0] == $past(cpu_vector_o))
    else $error("status differs from presentation");
  reset_out_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !cpu_irq_o && !irq_o && !multi_handler_o)
    else $error("output high after reset");
endmodule
bind vectored_interrupt_controller_regs vic_sva u_vic_sva (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .cpu_irq_o, .cpu_vector_o, .cpu_level_o, .multi_handler_o, .irq_o
);
`default_nettype wire
